// [src/gfp_frame_timing.sv]
// Genlock frame start pulse timing and divider configuration registers
//
// Function
// - Frame pulse is delayed by the programmed offset, counted in reference lines.
// - Charge pump bit 4 is inverted before use by PLL4, so zero means eight there; PLL1 takes bits 3..0 as written.
// - Smaller charge pump code gives smaller current for PLL1; PLL4 has bit 4 inverted, so its order differs.
// - Pulse rate is the selected HD or SD output clock over pixels per line times lines.
// - Three integrated PLLs give the HD, HD/1.001 and 67.5 MHz clocks.
// - Divider code 1 divides by 1, 0 by 2, 2 by 5.
// - When genlocked, reference frames reset the pulse logic every N frames.
//
// Added by the designer: the plain strobed port.
module gfp_frame_timing
    import gfp_pkg::*;
#(
    parameter int PW = 13,
    parameter int LW = 12
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sd_clk_en_i,
    input wire logic hd_clk_en_i,
    input wire logic horizontal_reference_input_i,
    input wire logic vertical_reference_input_i,
    input wire logic genlock_i,
    output logic frame_start_pulse_o,
    output logic frame_start_pulse_oe_n_o,
    output logic [1:0] hd_pll_sel_o,
    output logic sd_pll_sel_o,
    output logic sd_clk_oe_n_o,
    output logic hd_clk_oe_n_o,
    output logic [2:0] ref_div_value_o,
    output logic [12:0] feedback_divider_value_o,
    output logic [3:0] cp_pll1_o,
    output logic [3:0] cp_pll4_o
);
    `include "gfp_defines.svh"

    typedef struct packed {
        logic [7:0] ref_type;
        logic [7:0] ref_div;
        logic [12:0] feedback_divider_value;
        logic [7:0] cp;
        logic [7:0] clk_sel;
        logic [7:0] rst_hi;
        logic [4:0] rst_lo_bits;
        logic [7:0] rst_lo;
        logic [PW-1:0] ppl;
        logic [12:0] olpf;
        logic [LW-1:0] ilpf;
        logic [LW-1:0] tofs;
        logic [7:0] rdata;
        logic [PW-1:0] pix_cnt;
        logic [12:0] line_cnt;
        logic [LW-1:0] ref_line;
        logic [12:0] frame_cnt;
        logic [3:0] pulse_cnt;
        logic offset_bad;
        logic pulse;
        logic pulse_out;
        gfp_state_t state;
        logic [2:0] div_val;
        logic [3:0] cp4;
    } gfp_state_s_t;
    gfp_state_s_t s_q, s_d;

    logic horizontal_reference_input_rise;
    logic vref_rise;
    logic gen_sync;
    logic [2:0] div_val;
    logic [3:0] cp4;

    gfp_sync2 u_horizontal_reference_input (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .async_i(horizontal_reference_input_i),
        .level_o(),
        .rise_o(horizontal_reference_input_rise)
    );

    gfp_sync2 u_vref (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .async_i(vertical_reference_input_i),
        .level_o(),
        .rise_o(vref_rise)
    );

    gfp_sync2 u_glock (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .async_i(genlock_i),
        .level_o(gen_sync),
        .rise_o()
    );

    gfp_refdiv u_dec (
        .div_code_i(s_q.ref_div[1:0]),
        .cp_reg_i(s_q.cp),
        .div_value_o(div_val),
        .cp_pll4_o(cp4)
    );

    // Selected pulse timing clock enable: HD or SD output clock
    logic pix_tick;
    assign pix_tick = s_q.clk_sel[`GFP_BIT_TOF_CLK] ? hd_clk_en_i : sd_clk_en_i;

    logic [12:0] rst_count;
    assign rst_count = {s_q.rst_lo_bits, s_q.rst_lo};

    function automatic logic [7:0] rd_mux(input logic [7:0] a, input gfp_state_s_t s);
        case (a)
            `GFP_OFF_REF_TYPE: rd_mux = s.ref_type;
            `GFP_OFF_REF_DIV: rd_mux = s.ref_div;
            `GFP_OFF_FB_LO: rd_mux = s.feedback_divider_value[7:0];
            `GFP_OFF_FB_HI: rd_mux = {3'h0, s.feedback_divider_value[12:8]};
            `GFP_OFF_CP: rd_mux = s.cp;
            `GFP_OFF_CLK_SEL: rd_mux = s.clk_sel;
            `GFP_OFF_RST_LO: rd_mux = s.rst_lo;
            `GFP_OFF_RST_HI: rd_mux = {s.rst_hi[7:5], s.rst_lo_bits};
            `GFP_OFF_PPL_LO: rd_mux = s.ppl[7:0];
            `GFP_OFF_PPL_HI: rd_mux = {3'h0, s.ppl[12:8]};
            `GFP_OFF_OLPF_LO: rd_mux = s.olpf[7:0];
            `GFP_OFF_OLPF_HI: rd_mux = {3'h0, s.olpf[12:8]};
            `GFP_OFF_ILPF_LO: rd_mux = s.ilpf[7:0];
            `GFP_OFF_ILPF_HI: rd_mux = {4'h0, s.ilpf[11:8]};
            `GFP_OFF_TOFS_LO: rd_mux = s.tofs[7:0];
            `GFP_OFF_TOFS_HI: rd_mux = {4'h0, s.tofs[11:8]};
            `GFP_OFF_STATUS: rd_mux = {5'h00, s.offset_bad, s.state == GFP_ST_ARMED,
                s.pulse};
            default: rd_mux = 8'h00;
        endcase
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        s_d.div_val = div_val;
        s_d.cp4 = cp4;
        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                `GFP_OFF_REF_TYPE: s_d.ref_type = reg_wdata_i;
                `GFP_OFF_REF_DIV: s_d.ref_div = reg_wdata_i;
                `GFP_OFF_FB_LO: s_d.feedback_divider_value[7:0] = reg_wdata_i;
                `GFP_OFF_FB_HI: s_d.feedback_divider_value[12:8] = reg_wdata_i[4:0];
                `GFP_OFF_CP: s_d.cp = reg_wdata_i;
                `GFP_OFF_CLK_SEL: s_d.clk_sel = reg_wdata_i;
                `GFP_OFF_RST_LO: s_d.rst_lo = reg_wdata_i;
                `GFP_OFF_RST_HI: begin
                    s_d.rst_hi = reg_wdata_i;
                    s_d.rst_lo_bits = reg_wdata_i[4:0];
                end
                `GFP_OFF_PPL_LO: s_d.ppl[7:0] = reg_wdata_i;
                `GFP_OFF_PPL_HI: s_d.ppl[12:8] = reg_wdata_i[4:0];
                `GFP_OFF_OLPF_LO: s_d.olpf[7:0] = reg_wdata_i;
                `GFP_OFF_OLPF_HI: s_d.olpf[12:8] = reg_wdata_i[4:0];
                `GFP_OFF_ILPF_LO: s_d.ilpf[7:0] = reg_wdata_i;
                `GFP_OFF_ILPF_HI: s_d.ilpf[11:8] = reg_wdata_i[3:0];
                `GFP_OFF_TOFS_LO: s_d.tofs[7:0] = reg_wdata_i;
                `GFP_OFF_TOFS_HI: s_d.tofs[11:8] = reg_wdata_i[3:0];
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            s_d.rdata = rd_mux(reg_addr_i, s_q);
        end
        // Zero offset is invalid; flagged and treated as full frame
        s_d.offset_bad = (s_q.tofs == '0) || (s_q.tofs > s_q.ilpf);
        // Pulse stretch countdown
        if (s_q.pulse_cnt != 4'h0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - 4'h1;
        end
        s_d.pulse = (s_d.pulse_cnt != 4'h0);
        // Reference line counter, zeroed at each reference frame
        if (vref_rise) begin
            s_d.ref_line = '0;
        end else if (horizontal_reference_input_rise) begin
            s_d.ref_line = s_q.ref_line + LW'(1);
        end
        // Output pixel and line counters
        if (pix_tick) begin
            if (s_q.pix_cnt >= s_q.ppl - PW'(1)) begin
                s_d.pix_cnt = '0;
                if (s_q.line_cnt >= s_q.olpf - 13'h1) begin
                    s_d.line_cnt = '0;
                end else begin
                    s_d.line_cnt = s_q.line_cnt + 13'h1;
                end
            end else begin
                s_d.pix_cnt = s_q.pix_cnt + PW'(1);
            end
        end
        case (s_q.state)
            GFP_ST_IDLE: begin
                if (gen_sync && s_q.clk_sel[`GFP_BIT_FRAME_RESET_COUNT_EN]) begin
                    s_d.state = GFP_ST_RUN;
                    s_d.frame_cnt = '0;
                end
            end
            GFP_ST_RUN: begin
                // Count reference frames; every Nth one re-arms alignment
                if (vref_rise) begin
                    if (s_q.frame_cnt + 13'h1 >= rst_count) begin
                        s_d.frame_cnt = '0;
                        s_d.state = GFP_ST_ARMED;
                    end else begin
                        s_d.frame_cnt = s_q.frame_cnt + 13'h1;
                    end
                end
                if (!gen_sync || !s_q.clk_sel[`GFP_BIT_FRAME_RESET_COUNT_EN]) begin
                    s_d.state = GFP_ST_IDLE;
                end
            end
            GFP_ST_ARMED: begin
                // Frame starts seen while armed still count toward N
                if (vref_rise) begin
                    s_d.frame_cnt = s_q.frame_cnt + 13'h1;
                end
                // Offset reached in reference lines: realign the output frame
                if (horizontal_reference_input_rise && (s_q.ref_line + LW'(1) == s_q.tofs
                    || (s_q.offset_bad && s_q.ref_line + LW'(1) == s_q.ilpf))) begin
                    s_d.pix_cnt = '0;
                    s_d.line_cnt = '0;
                    s_d.pulse_cnt = `GFP_PULSE_LEN;
                    s_d.pulse = 1'b1;
                    // Full-frame offset lands on a frame start that may re-arm
                    if (vref_rise && s_q.frame_cnt + 13'h1 >= rst_count) begin
                        s_d.frame_cnt = '0;
                        s_d.state = GFP_ST_ARMED;
                    end else begin
                        s_d.state = GFP_ST_RUN;
                    end
                end
                if (!gen_sync || !s_q.clk_sel[`GFP_BIT_FRAME_RESET_COUNT_EN]) begin
                    s_d.state = GFP_ST_IDLE;
                end
            end
            default: s_d.state = GFP_ST_IDLE;
        endcase
        // Free run: one pulse per output frame at frame wrap
        if (pix_tick && s_d.pix_cnt == '0 && s_d.line_cnt == '0 && s_q.state != GFP_ST_ARMED
            && !(s_q.pix_cnt == '0 && s_q.line_cnt == '0)) begin
            s_d.pulse_cnt = `GFP_PULSE_LEN;
            s_d.pulse = 1'b1;
        end
        // Pin level with polarity applied, registered with the rest
        s_d.pulse_out = s_d.pulse ^ ~s_q.clk_sel[`GFP_BIT_TOF_POL];
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.ref_type <= `GFP_RST_REF_TYPE;
            s_q.ref_div <= `GFP_RST_REF_DIV;
            s_q.feedback_divider_value <= `GFP_RST_FB;
            s_q.cp <= `GFP_RST_CP;
            s_q.clk_sel <= `GFP_RST_CLK_SEL;
            s_q.rst_lo <= 8'h01;
            s_q.rst_lo_bits <= 5'h00;
            s_q.ppl <= `GFP_RST_PPL;
            s_q.olpf <= `GFP_RST_OLPF;
            s_q.ilpf <= `GFP_RST_ILPF;
            s_q.tofs <= `GFP_RST_TOFS;
            s_q.div_val <= `GFP_DIV_BY1;
            s_q.cp4 <= 4'h8;
            s_q.state <= GFP_ST_IDLE;
            s_q.pulse_out <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign frame_start_pulse_o = s_q.pulse_out;
    assign frame_start_pulse_oe_n_o = 1'b0;
    assign reg_rdata_o = s_q.rdata;
    assign hd_pll_sel_o = s_q.clk_sel[`GFP_BIT_HD_LSB +: 2];
    assign sd_pll_sel_o = s_q.clk_sel[`GFP_BIT_SD_SEL];
    assign sd_clk_oe_n_o = s_q.clk_sel[`GFP_BIT_SD_EN];
    assign hd_clk_oe_n_o = s_q.clk_sel[`GFP_BIT_HD_EN];
    assign ref_div_value_o = s_q.div_val;
    assign feedback_divider_value_o = s_q.feedback_divider_value;
    assign cp_pll1_o = s_q.cp[3:0];
    assign cp_pll4_o = s_q.cp4;

    a_div_decode: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_q.ref_div[1:0] == 2'h2 && $stable(s_q.ref_div) |=> ref_div_value_o == 3'h5)
        else $error("divider code 2 not decoded to 5");

    a_cp_invert: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $stable(s_q.cp) |=> cp_pll4_o[3] == ~$past(s_q.cp[4]))
        else $error("charge pump bit 4 not inverted");

    a_pix_bound: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !reg_wr_i && s_q.ppl != '0 && s_q.pix_cnt < s_q.ppl |=> s_q.pix_cnt < s_q.ppl)
        else $error("pixel counter passed line length");

    sequence s_armed_hit;
        s_q.state == GFP_ST_ARMED && horizontal_reference_input_rise && !s_q.offset_bad
            && s_q.ref_line + LW'(1) == s_q.tofs;
    endsequence

    a_offset_align: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_armed_hit |=> s_q.pulse && s_q.line_cnt == '0 ##1 s_q.pulse)
        else $error("pulse not issued at offset line");

    a_genlock_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !gen_sync && s_q.state == GFP_ST_RUN |=> s_q.state == GFP_ST_IDLE)
        else $error("pulse logic kept genlock after release");

    a_pulse_width: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $rose(s_q.pulse) |-> s_q.pulse [*4])
        else $error("frame pulse shorter than set width");

    a_rdata_idle: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read");

    a_zero_offset: assert property (@(posedge clock_i) disable iff (!rstn_i)
        s_q.tofs == '0 |=> s_q.offset_bad)
        else $error("zero offset not flagged");

    a_armed_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !gen_sync && s_q.state == GFP_ST_ARMED |=> s_q.state == GFP_ST_IDLE)
        else $error("armed state kept after genlock release");

    a_line_bound: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !reg_wr_i && s_q.olpf != '0 && s_q.line_cnt < s_q.olpf |=> s_q.line_cnt < s_q.olpf)
        else $error("line counter passed frame length");

    a_out_polarity: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $stable(s_q.clk_sel)
        |-> frame_start_pulse_o == (s_q.pulse ^ ~s_q.clk_sel[`GFP_BIT_TOF_POL]))
        else $error("frame pulse level does not follow polarity");
endmodule // gfp_frame_timing

// [shared/gfp_defines.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef GFP_DEFINES_SVH
`define GFP_DEFINES_SVH

`define GFP_OFF_REF_TYPE 8'h02
`define GFP_OFF_REF_DIV 8'h03
`define GFP_OFF_FB_LO 8'h04
`define GFP_OFF_FB_HI 8'h05
`define GFP_OFF_CP 8'h06
`define GFP_OFF_CLK_SEL 8'h08
`define GFP_OFF_RST_LO 8'h09
`define GFP_OFF_RST_HI 8'h0A
`define GFP_OFF_PPL_LO 8'h0B
`define GFP_OFF_PPL_HI 8'h0C
`define GFP_OFF_OLPF_LO 8'h0D
`define GFP_OFF_OLPF_HI 8'h0E
`define GFP_OFF_ILPF_LO 8'h0F
`define GFP_OFF_ILPF_HI 8'h10
`define GFP_OFF_TOFS_LO 8'h11
`define GFP_OFF_TOFS_HI 8'h12
`define GFP_OFF_STATUS 8'h13

`define GFP_BIT_REF_TYPE 4
`define GFP_BIT_CP_INV 4
`define GFP_BIT_SD_SEL 0
`define GFP_BIT_SD_EN 1
`define GFP_BIT_HD_LSB 2
`define GFP_BIT_HD_EN 4
`define GFP_BIT_TOF_CLK 5
`define GFP_BIT_TOF_POL 6
`define GFP_BIT_FRAME_RESET_COUNT_EN 7

`define GFP_RST_REF_TYPE 8'h00
`define GFP_RST_REF_DIV 8'h01
`define GFP_RST_FB 13'h06B4
`define GFP_RST_CP 8'h00
`define GFP_RST_CLK_SEL 8'h04
`define GFP_RST_RST_CNT 5'h01
`define GFP_RST_PPL 13'h06B4
`define GFP_RST_OLPF 13'h020D
`define GFP_RST_ILPF 12'h20D
`define GFP_RST_TOFS 12'h20D

`define GFP_DIV_BY1 3'h1
`define GFP_DIV_BY2 3'h2
`define GFP_DIV_BY5 3'h5

`define GFP_PULSE_LEN 4'h4

`endif

// [shared/gfp_pkg.sv]
// Types shared by the frame pulse timing block
package gfp_pkg;
    typedef enum logic [1:0] {
        GFP_PLL_VCXO,
        GFP_PLL_HD,
        GFP_PLL_HD_1001,
        GFP_PLL_SD
    } gfp_pll_t;

    typedef enum logic [1:0] {
        GFP_ST_IDLE,
        GFP_ST_RUN,
        GFP_ST_ARMED
    } gfp_state_t;
endpackage

// [src/gfp_sync2.sv]
// Two flip-flop synchroniser with rising edge detect behind it
module gfp_sync2 (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } gfp_sync_t;
    gfp_sync_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.meta = async_i;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.sync;
    assign rise_o = s_q.sync & ~s_q.last;
endmodule // gfp_sync2

// [src/gfp_refdiv.sv]
// Reference divider code decode and charge pump current decode
module gfp_refdiv
    import gfp_pkg::*;
(
    input wire logic [1:0] div_code_i,
    input wire logic [7:0] cp_reg_i,
    output logic [2:0] div_value_o,
    output logic [3:0] cp_pll4_o
);
    `include "gfp_defines.svh"

    always_comb begin
        case (div_code_i)
            2'h1: div_value_o = `GFP_DIV_BY1;
            2'h0: div_value_o = `GFP_DIV_BY2;
            2'h2: div_value_o = `GFP_DIV_BY5;
            default: div_value_o = `GFP_DIV_BY1;
        endcase
    end

    // Fourth PLL code: bit 4 inverted into bit 3, bits 2..0 straight, bit 3 of the register dropped
    assign cp_pll4_o = {~cp_reg_i[`GFP_BIT_CP_INV], cp_reg_i[2:0]};
endmodule // gfp_refdiv

// [dv/gfp_ref_source.sv]
// Behavioural reference sync source: line pulses and frame pulses
module gfp_ref_source #(
    parameter int LINE_CYC = 10,
    parameter int LINES = 4
) (
    input wire logic clock_i,
    input wire logic run_i,
    output logic horizontal_reference_input_o,
    output logic vref_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int pc;
    int lc;

    initial begin
        horizontal_reference_input_o = 1'b0;
        vref_o = 1'b0;
        pc = 0;
        lc = 0;
    end

    // Frame pulse rides on the first line pulse; both idle low when stopped
    always @(posedge clock_i) begin
        if (!run_i) begin
            pc <= 0;
            lc <= 0;
            horizontal_reference_input_o <= 1'b0;
            vref_o <= 1'b0;
        end else begin
            pc <= (pc == LINE_CYC - 1) ? 0 : pc + 1;
            if (pc == LINE_CYC - 1) begin
                lc <= (lc == LINES - 1) ? 0 : lc + 1;
            end
            horizontal_reference_input_o <= (pc < 2);
            vref_o <= (pc < 2) && (lc == 0);
        end
    end
endmodule // gfp_ref_source

// [dv/tb_gfp_frame_timing.sv]
// Self-checking bench for the frame pulse timing block
module tb_gfp_frame_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic sd_en = 1'b0;
    logic genlock = 1'b0;
    logic run = 1'b0;
    logic horizontal_reference_input, vref, vref_q = 1'b0;
    logic [7:0] reg_rdata_o;
    logic pulse, pulse_oe_n, sd_sel, sd_oe_n, hd_oe_n;
    logic [1:0] hd_sel;
    logic [2:0] div_val;
    logic [12:0] fb_val;
    logic [3:0] cp1, cp4;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int last_vref = 0;

    gfp_frame_timing DUT (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sd_clk_en_i(sd_en), .hd_clk_en_i(1'b1),
        .horizontal_reference_input_i(horizontal_reference_input), .vertical_reference_input_i(vref),
        .genlock_i(genlock), .frame_start_pulse_o(pulse), .frame_start_pulse_oe_n_o(pulse_oe_n),
        .hd_pll_sel_o(hd_sel), .sd_pll_sel_o(sd_sel), .sd_clk_oe_n_o(sd_oe_n),
        .hd_clk_oe_n_o(hd_oe_n), .ref_div_value_o(div_val), .feedback_divider_value_o(fb_val),
        .cp_pll1_o(cp1), .cp_pll4_o(cp4));
    gfp_ref_source #(.LINE_CYC(10), .LINES(4)) u_src (.clock_i(clock_i), .run_i(run),
        .horizontal_reference_input_o(horizontal_reference_input), .vref_o(vref));

    always #4 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        sd_en <= ~sd_en;
        vref_q <= vref;
        if (vref && !vref_q) begin
            last_vref <= cyc;
        end
    end

    task automatic end_sim;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic rdchk(string n, logic [7:0] a, logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(n, {8'h00, e}, {8'h00, d});
    endtask

    // Waits for a rising pulse edge, returns its cycle, last frame start and width
    task automatic next_pulse(output int t, output int v, output int w);
        logic p;
        int i;
        p = 1'b1;
        for (i = 0; i < 400; i++) begin
            @(posedge clock_i);
            #1;
            if (pulse === 1'b1 && p === 1'b0) break;
            p = pulse;
        end
        t = cyc;
        v = last_vref;
        w = 0;
        while (pulse === 1'b1 && w < 20) begin
            w++;
            @(posedge clock_i);
            #1;
        end
    endtask

    task automatic t_defaults;
        logic [15:0] tab [16] = '{16'h0200, 16'h0301, 16'h04B4, 16'h0506, 16'h0600, 16'h0804,
            16'h0901, 16'h0A00, 16'h0BB4, 16'h0C06, 16'h0D0D, 16'h0E02, 16'h0F0D, 16'h1002,
            16'h110D, 16'h1202};
        int i;
        for (i = 0; i < 16; i++) begin
            rdchk("reset_value", tab[i][15:8], tab[i][7:0]);
        end
        wr(8'h07, 8'hFF);
        rdchk("unmapped", 8'h07, 8'h00);
        chk("pulse_oe_n", 16'h0000, {15'h0, pulse_oe_n});
    endtask

    task automatic t_ref_cfg;
        logic [7:0] ty [4] = '{8'h00, 8'h00, 8'h10, 8'h00};
        logic [1:0] dv [4] = '{2'h1, 2'h0, 2'h1, 2'h2};
        logic [2:0] ed [4] = '{3'h1, 3'h2, 3'h1, 3'h5};
        logic [12:0] fb [4] = '{13'd1716, 13'd1125, 13'd1, 13'd3003};
        logic [12:0] il [4] = '{13'd525, 13'd1920, 13'd4000, 13'd750};
        int i;
        for (i = 0; i < 4; i++) begin
            wr(8'h02, ty[i]);
            wr(8'h03, {6'h00, dv[i]});
            wr(8'h04, fb[i][7:0]);
            wr(8'h05, {3'h0, fb[i][12:8]});
            wr(8'h0F, il[i][7:0]);
            wr(8'h10, {4'h0, il[i][11:8]});
            @(posedge clock_i);
            #1;
            chk("ref_div_value", {13'h0, ed[i]}, {13'h0, div_val});
            chk("feedback_value", {3'h0, fb[i]}, {3'h0, fb_val});
            rdchk("ref_type", 8'h02, ty[i]);
            rdchk("in_lines_hi", 8'h10, {4'h0, il[i][11:8]});
        end
    endtask

    task automatic t_charge_pump;
        int i;
        for (i = 0; i < 32; i++) begin
            wr(8'h06, 8'(i));
            @(posedge clock_i);
            #1;
            chk("cp_pll1", 16'(i % 16), {12'h0, cp1});
            chk("cp_pll4", {12'h0, ~i[4], i[2:0]}, {12'h0, cp4});
        end
    endtask

    task automatic t_clock_sel;
        logic [2:0] i;
        for (int k = 0; k < 8; k++) begin
            i = 3'(k);
            wr(8'h08, {3'h0, i[1], i[1:0], i[0], i[2]});
            @(posedge clock_i);
            #1;
            chk("hd_pll_sel", {14'h0, i[1:0]}, {14'h0, hd_sel});
            chk("sd_pll_sel", {15'h0, i[2]}, {15'h0, sd_sel});
            chk("clk_oe_n", {14'h0, i[1], i[0]}, {14'h0, hd_oe_n, sd_oe_n});
        end
    endtask

    task automatic t_free_run;
        int t0, t1, v, w, s;
        wr(8'h0B, 8'd10);
        wr(8'h0C, 8'h00);
        wr(8'h0D, 8'd4);
        wr(8'h0E, 8'h00);
        for (s = 0; s < 2; s++) begin
            wr(8'h08, (s == 1) ? 8'h60 : 8'h40);
            next_pulse(t0, v, w);
            next_pulse(t0, v, w);
            next_pulse(t1, v, w);
            chk("free_period", (s == 1) ? 16'd40 : 16'd80, 16'(t1 - t0));
            chk("pulse_width", 16'd4, 16'(w));
        end
    endtask

    task automatic t_genlock;
        int t0, t1, v, w, k, j;
        int d [3];
        logic [7:0] st;
        wr(8'h0F, 8'd4);
        wr(8'h10, 8'h00);
        wr(8'h09, 8'd2);
        wr(8'h0A, 8'h00);
        wr(8'h0D, 8'd8);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h00);
        rd(8'h13, st);
        chk("offset_invalid", 16'h0001, {15'h0, st[2]});
        wr(8'h08, 8'hE0);
        genlock <= 1'b1;
        run <= 1'b1;
        for (k = 0; k < 3; k++) begin
            wr(8'h11, 8'(4 - (2 - k)));
            for (j = 0; j < 3; j++) begin
                next_pulse(t0, v, w);
            end
            next_pulse(t0, v, w);
            d[k] = t0 - v;
            next_pulse(t1, v, w);
            chk("lock_period", 16'd80, 16'(t1 - t0));
        end
        chk("offset_step", 16'd10, 16'(d[1] - d[0]));
        chk("offset_full", 16'd20, 16'(d[0] - d[2]));
        wr(8'h11, 8'd4);
        rd(8'h13, st);
        chk("offset_valid", 16'h0000, {15'h0, st[2]});
        genlock <= 1'b0;
        run <= 1'b0;
    endtask

    initial begin
        repeat (2) @(posedge clock_i);
        #1;
        chk("pulse_in_reset", 16'h0001, {15'h0, pulse});
        rstn_i <= 1'b1;
        t_defaults();
        t_ref_cfg();
        t_charge_pump();
        t_clock_sel();
        t_free_run();
        t_genlock();
        end_sim();
    end

    initial begin
        #200000;
        n_errors++;
        end_sim();
    end
endmodule // tb_gfp_frame_timing
